// file: design/phase_seq_defs.vh
/*
 * Constants for the deposition phase sequencer: register map, field
 * positions, encodings, limits and timing.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
 */
`ifndef PHASE_SEQ_DEFS_VH
`define PHASE_SEQ_DEFS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define A_CTRL    6'h00
`define A_STATUS  6'h04
`define A_FIRST_POWER_RAMP   6'h08
`define A_RAMP2   6'h0C
`define A_SOAK    6'h10
`define A_CAPT    6'h14
`define A_FEED    6'h18
`define A_TIMES   6'h1C
`define A_SAMPLE  6'h20
`define A_LAYER   6'h24
`define A_PROC    6'h28
`define A_PSEL    6'h2C
`define A_POWER   6'h30

// ---------------------------------------------------------------
// fields
// ---------------------------------------------------------------
`define C_AUTO    0
`define C_ACT     2:1
`define C_SMODE   4:3
`define C_START   8
`define C_STOP    9
`define S_PHASE   3:0
`define S_CAPERR  4
`define S_RATEERR 5
`define S_SHUT    6
`define S_HOLD    7
`define S_LAYER   25:16
`define RP_PWR    7:0
`define RP_TIME   23:8
`define LO_HALF   15:0
`define HI_HALF   31:16
`define CP_PCT    23:16
`define FD_PWR    7:0
`define FD_IDLE   15:8
`define L_IDX     9:0
`define L_FILM    14:10
`define L_AUTO    15
`define L_MASK    17:16
`define LM_FILM   4:0
`define LM_AUTO   5
`define LM_MASK   7:6
`define P_NUM     4:0
`define P_FIRST   14:5
`define P_COUNT   24:15

// ---------------------------------------------------------------
// encodings and limits
// ---------------------------------------------------------------
`define ACT_IGNORE 2'h0
`define ACT_STOP   2'h1
`define ACT_HOLD   2'h2
`define SM_CONT    2'h0
`define SM_TIME    2'h1
`define SM_ACC     2'h2
`define MAX_FILMS  25
`define MAX_PROCS  25
`define MAX_LAYERS 1000
`define NUM_OUT    2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define TICK_NS       1000000

`endif

// file: design/deposition_phase_sequencer.v
/*
 * Deposition phase sequencer: steps each layer of the selected process
 * through ramps, soaks, indexer, shutter capture, rate-controlled
 * deposition, feed and idle power, for up to two concurrent outputs.
 * Assumes rate deviation, closed-loop power, rate-fail and final-thickness
 * signals come synchronous to mclk from the rate controller outside.
 */
// Notes on behaviour
// - stop command ends deposition at once and forces output power to zero
// - manual mode after start: output follows the operator knob directly
// - switching manual to auto hands output to the closed-loop controller
// - phases: first_power_ramp, soak1, ramp2, soak2, index, shutter delay, deposit, feed ramp, feed, idle
// - first ramp starts at zero power, rises over its time to its level
// - second ramp moves from soak1 level to second level over its time
// - soaks hold their level; soak1 for its programmed time
// - shutter stays closed until deviation within capture, then deposit
// - shutter delay bounds the capture wait; expiry is a capture failure
// - zero delay and zero capture open the shutter without waiting
// - more than one active output makes the layer co-deposition
// - deposit only after every active film captured, else error
// - rate-control error action: ignore, stop, or hold power and extrapolate
// - continuous sampling disabled; timed sampling alternates closed and open
// - accuracy sampling closes fixed time, opens until rate is reached
// - recipe store: 25 films, 25 processes, 1000 layers in all
// - auto-start layer follows at once; manual layer waits for start
// - final thickness ends deposition and starts the feed ramp to feed power, then feed and idle
`timescale 1ns/1ns
`include "phase_seq_defs.vh"

module deposition_phase_sequencer #(
    parameter TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // register bus
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // operator controls
    input  wire        start_in,
    input  wire        stop_in,
    input  wire [7:0]  knob_power,
    // rate controller and sensors
    input  wire [7:0]  rate_dev0,
    input  wire [7:0]  rate_dev1,
    input  wire [7:0]  pid_power0,
    input  wire [7:0]  pid_power1,
    input  wire        rate_fail,
    input  wire        thick_done,
    // source and shutter
    output wire [7:0]  power0,
    output wire [7:0]  power1,
    output wire        shutter_open,
    output wire        thk_hold
);

localparam [3:0] PH_IDLE = 4'h0, PH_FIRST_POWER_RAMP = 4'h1, PH_SOAK1 = 4'h2, PH_RAMP2 = 4'h3,
                 PH_SOAK2 = 4'h4, PH_INDEX = 4'h5, PH_SHDLY = 4'h6, PH_DEP = 4'h7,
                 PH_FRAMP = 4'h8, PH_FEED = 4'h9, PH_IDLEPW = 4'hA, PH_WAIT = 4'hB;

// ----------------
// bus slave and registers
// ----------------
reg        wait_r;
reg [31:0] rdata_r;
reg [4:0]  ctrl_r;
reg [23:0] r1_r;
reg [23:0] r2_r;
reg [31:0] soak_r;
reg [23:0] capt_r;
reg [31:0] feed_r;
reg [31:0] times_r;
reg [31:0] samp_r;
reg [4:0]  psel_r;
reg [31:0] rd_mux;
reg [7:0]  layer_mem  [0:`MAX_LAYERS-1];
reg [9:0]  proc_first [0:`MAX_PROCS-1];
reg [9:0]  proc_cnt   [0:`MAX_PROCS-1];
reg [3:0]  phase_r;
reg [9:0]  layer_r;
reg [9:0]  left_r;
reg [1:0]  mask_r;
reg        shut_r;
reg        hold_r;
reg        cap_err_r;
reg        rate_err_r;
reg [7:0]  pw_r [0:`NUM_OUT-1];

wire        wr_ok = avs_write && !wait_r;
wire [31:0] wd    = avs_writedata;
wire        ctrl_wr = wr_ok && avs_address == `A_CTRL;
wire        start_cmd = (ctrl_wr && wd[`C_START]) || start_in;
wire        stop_cmd  = (ctrl_wr && wd[`C_STOP]) || stop_in;
wire [10:0] pend = {1'b0, wd[`P_FIRST]} + {1'b0, wd[`P_COUNT]};

assign avs_waitrequest = wait_r;
assign avs_readdata    = rdata_r;

always @* begin
    rd_mux = 32'h00000000;
    case (avs_address)
        `A_CTRL:   rd_mux[4:0] = ctrl_r;
        `A_STATUS: begin
            rd_mux[`S_PHASE]   = phase_r;
            rd_mux[`S_CAPERR]  = cap_err_r;
            rd_mux[`S_RATEERR] = rate_err_r;
            rd_mux[`S_SHUT]    = shut_r;
            rd_mux[`S_HOLD]    = hold_r;
            rd_mux[`S_LAYER]   = layer_r;
        end
        `A_FIRST_POWER_RAMP:  rd_mux[23:0] = r1_r;
        `A_RAMP2:  rd_mux[23:0] = r2_r;
        `A_SOAK:   rd_mux = soak_r;
        `A_CAPT:   rd_mux[23:0] = capt_r;
        `A_FEED:   rd_mux = feed_r;
        `A_TIMES:  rd_mux = times_r;
        `A_SAMPLE: rd_mux = samp_r;
        `A_PSEL:   rd_mux[4:0] = psel_r;
        `A_POWER:  rd_mux[15:0] = {pw_r[1], pw_r[0]};
        default:   rd_mux = 32'h00000000;
    endcase
end

// one wait cycle per access: data latched on the first edge, taken on the second
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        wait_r  <= 1'b1;
        rdata_r <= 32'h00000000;
        ctrl_r  <= 5'h00;
        r1_r    <= 24'h000000;
        r2_r    <= 24'h000000;
        soak_r  <= 32'h00000000;
        capt_r  <= 24'h000000;
        feed_r  <= 32'h00000000;
        times_r <= 32'h00000000;
        samp_r  <= 32'h00000000;
        psel_r  <= 5'h00;
    end else begin
        if ((avs_read || avs_write) && wait_r) begin
            wait_r  <= 1'b0;
            if (avs_read) rdata_r <= rd_mux;
        end else begin
            wait_r  <= 1'b1;
        end
        if (wr_ok) begin
            case (avs_address)
                `A_CTRL:   ctrl_r  <= wd[4:0];
                `A_FIRST_POWER_RAMP:  r1_r    <= wd[23:0];
                `A_RAMP2:  r2_r    <= wd[23:0];
                `A_SOAK:   soak_r  <= wd;
                `A_CAPT:   capt_r  <= wd[23:0];
                `A_FEED:   feed_r  <= wd;
                `A_TIMES:  times_r <= wd;
                `A_SAMPLE: samp_r  <= wd;
                `A_PSEL:   if (wd[`P_NUM] < `MAX_PROCS) psel_r <= wd[`P_NUM];
                default:   ;
            endcase
        end
    end
end

// ----------------
// recipe store
// ----------------
// out-of-range entries are dropped silently so the store never aliases
always @(posedge mclk) begin
    if (wr_ok && avs_address == `A_LAYER && wd[`L_IDX] < `MAX_LAYERS &&
        wd[`L_FILM] != 5'h00 && wd[`L_FILM] <= `MAX_FILMS)
        layer_mem[wd[`L_IDX]] <= {wd[`L_MASK], wd[`L_AUTO], wd[`L_FILM]};
    if (wr_ok && avs_address == `A_PROC && wd[`P_NUM] < `MAX_PROCS &&
        pend <= `MAX_LAYERS) begin
        proc_first[wd[`P_NUM]] <= wd[`P_FIRST];
        proc_cnt[wd[`P_NUM]]   <= wd[`P_COUNT];
    end
end

// ----------------
// time base
// ----------------
reg  [16:0] tick_cnt_r;
reg         tick_r;

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        tick_cnt_r <= 17'h00000;
        tick_r     <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
        tick_cnt_r <= 17'h00000;
        tick_r     <= 1'b1;
    end else begin
        tick_cnt_r <= tick_cnt_r + 17'h00001;
        tick_r     <= 1'b0;
    end
end

// ----------------
// phase timing and ramp profile
// ----------------
reg  [15:0] cnt_r;
reg  [15:0] scnt_r;
reg         sopen_r;
reg  [7:0]  base_r;
reg  [7:0]  prof_r;
reg  [15:0] td;
reg  [7:0]  rtgt;
reg         is_ramp;
reg         timed;

always @* begin
    td      = 16'h0000;
    rtgt    = prof_r;
    is_ramp = 1'b0;
    timed   = 1'b1;
    case (phase_r)
        PH_FIRST_POWER_RAMP: begin td = r1_r[`RP_TIME]; rtgt = r1_r[`RP_PWR]; is_ramp = 1'b1; end
        PH_SOAK1: td = soak_r[`LO_HALF];
        PH_RAMP2: begin td = r2_r[`RP_TIME]; rtgt = r2_r[`RP_PWR]; is_ramp = 1'b1; end
        PH_SOAK2: td = soak_r[`HI_HALF];
        PH_INDEX: td = times_r[`HI_HALF];
        PH_FRAMP: begin td = feed_r[`HI_HALF]; rtgt = feed_r[`FD_PWR]; is_ramp = 1'b1; end
        PH_FEED:  td = times_r[`LO_HALF];
        default:  timed = 1'b0;
    endcase
end

wire [16:0]        cnt_inc  = {1'b0, cnt_r} + 17'h00001;
wire [16:0]        scnt_inc = {1'b0, scnt_r} + 17'h00001;
wire [15:0]        rdiv     = (td == 16'h0000) ? 16'h0001 : td;
wire signed [8:0]  rdiff    = $signed({1'b0, rtgt}) - $signed({1'b0, base_r});
wire signed [25:0] rprod    = rdiff * $signed({1'b0, cnt_r});
wire signed [25:0] rstep    = rprod / $signed({10'h000, rdiv});
wire [7:0]         rval     = base_r + rstep[7:0];
wire               ph_done  = td == 16'h0000 || (tick_r && cnt_inc >= {1'b0, td});
wire [15:0]        s_len    = sopen_r ? samp_r[`HI_HALF] : samp_r[`LO_HALF];
wire [9:0]         nlayer   = layer_r + 10'h001;
wire [9:0]         pfirst   = proc_first[psel_r];
wire               no_capt  = capt_r[`LO_HALF] == 16'h0000 && capt_r[`CP_PCT] == 8'h00;
wire [7:0]         dep_pw   = mask_r[0] ? pw_r[0] : pw_r[1];

// ----------------
// per-output capture and power
// ----------------
wire [15:0] dev_all = {rate_dev1, rate_dev0};
wire [15:0] pid_all = {pid_power1, pid_power0};
wire [1:0]  cap_ok;
wire        all_cap = &cap_ok;

genvar gi;
generate
    for (gi = 0; gi < `NUM_OUT; gi = gi + 1) begin : g_out
        // an idle output never blocks co-deposition capture
        assign cap_ok[gi] = !mask_r[gi] || dev_all[gi*8 +: 8] <= capt_r[`CP_PCT];
        always @(posedge mclk or negedge rst_n) begin
            if (!rst_n)
                pw_r[gi] <= 8'h00;
            else if (stop_cmd || phase_r == PH_IDLE || !mask_r[gi])
                pw_r[gi] <= 8'h00;
            else if (phase_r == PH_DEP) begin
                if (hold_r)
                    pw_r[gi] <= pw_r[gi];
                else if (ctrl_r[`C_AUTO])
                    pw_r[gi] <= pid_all[gi*8 +: 8];
                else
                    pw_r[gi] <= knob_power;
            end else
                pw_r[gi] <= prof_r;
        end
    end
endgenerate

assign power0       = pw_r[0];
assign power1       = pw_r[1];
assign shutter_open = shut_r;
assign thk_hold     = hold_r;

// ----------------
// sequencer
// ----------------
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        phase_r    <= PH_IDLE;
        cnt_r      <= 16'h0000;
        scnt_r     <= 16'h0000;
        sopen_r    <= 1'b0;
        base_r     <= 8'h00;
        prof_r     <= 8'h00;
        layer_r    <= 10'h000;
        left_r     <= 10'h000;
        mask_r     <= 2'h0;
        shut_r     <= 1'b0;
        hold_r     <= 1'b0;
        cap_err_r  <= 1'b0;
        rate_err_r <= 1'b0;
    end else if (stop_cmd) begin
        phase_r <= PH_IDLE;
        prof_r  <= 8'h00;
        shut_r  <= 1'b0;
        hold_r  <= 1'b0;
    end else if (start_cmd && (phase_r == PH_IDLE || phase_r == PH_WAIT)) begin
        cap_err_r  <= 1'b0;
        rate_err_r <= 1'b0;
        cnt_r      <= 16'h0000;
        scnt_r     <= 16'h0000;
        sopen_r    <= 1'b1;
        base_r     <= 8'h00;
        prof_r     <= 8'h00;
        hold_r     <= 1'b0;
        if (phase_r == PH_IDLE || left_r == 10'h000) begin
            layer_r <= pfirst;
            left_r  <= proc_cnt[psel_r];
            mask_r  <= layer_mem[pfirst][`LM_MASK];
        end else
            mask_r  <= layer_mem[layer_r][`LM_MASK];
        // manual control skips conditioning and puts the knob on the output
        phase_r <= ctrl_r[`C_AUTO] ? PH_FIRST_POWER_RAMP : PH_DEP;
        shut_r  <= !ctrl_r[`C_AUTO];
    end else if (timed) begin
        if (ph_done) begin
            phase_r <= phase_r + 4'h1;
            cnt_r   <= 16'h0000;
            prof_r  <= rtgt;
            base_r  <= rtgt;
        end else begin
            prof_r <= is_ramp ? rval : prof_r;
            if (tick_r)
                cnt_r <= cnt_inc[15:0];
        end
    end else begin
        case (phase_r)
            PH_SHDLY: begin
                if (no_capt || all_cap) begin
                    phase_r <= PH_DEP;
                    shut_r  <= 1'b1;
                    sopen_r <= 1'b1;
                    scnt_r  <= 16'h0000;
                end else if (tick_r && cnt_inc >= {1'b0, capt_r[`LO_HALF]} ||
                             capt_r[`LO_HALF] == 16'h0000) begin
                    cap_err_r <= 1'b1;
                    phase_r   <= PH_IDLE;
                    prof_r    <= 8'h00;
                end else if (tick_r)
                    cnt_r <= cnt_inc[15:0];
            end
            PH_DEP: begin
                case (ctrl_r[`C_SMODE])
                    `SM_TIME: begin
                        if (tick_r && scnt_inc >= {1'b0, s_len}) begin
                            sopen_r <= !sopen_r;
                            scnt_r  <= 16'h0000;
                        end else if (tick_r)
                            scnt_r <= scnt_inc[15:0];
                        shut_r <= sopen_r;
                    end
                    `SM_ACC: begin
                        if (sopen_r && all_cap) begin
                            sopen_r <= 1'b0;
                            scnt_r  <= 16'h0000;
                        end else if (!sopen_r && tick_r &&
                                     scnt_inc >= {1'b0, samp_r[`LO_HALF]})
                            sopen_r <= 1'b1;
                        else if (tick_r)
                            scnt_r <= scnt_inc[15:0];
                        shut_r <= sopen_r;
                    end
                    default: shut_r <= 1'b1;
                endcase
                if (thick_done) begin
                    phase_r <= PH_FRAMP;
                    shut_r  <= 1'b0;
                    hold_r  <= 1'b0;
                    cnt_r   <= 16'h0000;
                    base_r  <= dep_pw;
                    prof_r  <= dep_pw;
                end else if (rate_fail && !hold_r) begin
                    if (ctrl_r[`C_ACT] == `ACT_STOP) begin
                        rate_err_r <= 1'b1;
                        phase_r    <= PH_IDLE;
                        prof_r     <= 8'h00;
                        shut_r     <= 1'b0;
                    end else if (ctrl_r[`C_ACT] == `ACT_HOLD) begin
                        rate_err_r <= 1'b1;
                        hold_r     <= 1'b1;
                    end
                end
            end
            PH_IDLEPW: begin
                prof_r <= feed_r[`FD_IDLE];
                left_r <= left_r - 10'h001;
                if (left_r > 10'h001) begin
                    layer_r <= nlayer;
                    mask_r  <= layer_mem[nlayer][`LM_MASK];
                    if (layer_mem[nlayer][`LM_AUTO]) begin
                        phase_r <= PH_FIRST_POWER_RAMP;
                        prof_r  <= 8'h00;
                        base_r  <= 8'h00;
                        cnt_r   <= 16'h0000;
                    end else
                        phase_r <= PH_WAIT;
                end else
                    phase_r <= PH_WAIT;
            end
            PH_IDLE, PH_WAIT: ;
            default: phase_r <= PH_IDLE;
        endcase
    end
end

endmodule // deposition_phase_sequencer

// file: dv/phase_seq_properties.sv
/* Port-level checks for the deposition phase sequencer.
   Assumes one clock domain, mclk, with asynchronous active-low rst_n. */
`timescale 1ns/1ns
module phase_seq_properties (
    // clock and reset
    input wire        mclk,
    input wire        rst_n,
    // register bus
    input wire [5:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // controls and sensors
    input wire        stop_in,
    input wire        rate_fail,
    input wire        thick_done,
    // source side
    input wire [7:0]  power0,
    input wire [7:0]  power1,
    input wire        thk_hold
);
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ----------------
    // stop and hold
    // ----------------
    sequence s_stop_seen; stop_in; endsequence
    sequence s_powers_zero; (power0 == 8'h00 && power1 == 8'h00) [*2]; endsequence
    AST_STOP_ZERO: assert property (s_stop_seen |-> ##3 s_powers_zero)
        else $error("output power not zero after stop");
    AST_HOLD_CAUSE: assert property ($rose(thk_hold) |-> $past(rate_fail) || $past(rate_fail, 2))
        else $error("hold mode entered without a rate failure");
    // hold freezes power unless a stop or end of film intervenes
    AST_HOLD_FROZEN: assert property (thk_hold && $past(thk_hold) && $past(thk_hold, 2)
        && !$past(stop_in) && !$past(stop_in, 2) && !$past(thick_done) && !$past(thick_done, 2)
        |-> $stable(power0) && $stable(power1))
        else $error("power moved while in hold mode");
    // ----------------
    // register bus handshake
    // ----------------
    AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait state");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_WAIT_CAUSE: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
        else $error("waitrequest dropped with no request");
    AST_RDATA_HOLD: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    AST_UNMAPPED_ZERO: assert property (avs_read && avs_waitrequest && avs_address > 6'h30
        |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");
    AST_CTRL_PULSES: assert property (avs_read && avs_waitrequest && avs_address == 6'h00
        |=> avs_readdata[9:8] == 2'h0)
        else $error("start or stop bit read back as set");
endmodule // phase_seq_properties

bind deposition_phase_sequencer phase_seq_properties chk_u (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .stop_in(stop_in), .rate_fail(rate_fail), .thick_done(thick_done),
    .power0(power0), .power1(power1), .thk_hold(thk_hold));

// file: dv/source_model.sv
/* Far-side model: supply loop, shutter and quartz rate sensors.
   Assumes the bench steers rate settling, rate failure and end of film. */
`timescale 1ns/1ns
module source_model (
    // clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // from the sequencer
    input  wire       shutter_open,
    // bench steering
    input  wire       settle,
    input  wire       fail_req,
    input  wire       done_req,
    // to the sequencer
    output reg  [7:0] rate_dev0,
    output reg  [7:0] rate_dev1,
    output reg  [7:0] pid_power0,
    output reg  [7:0] pid_power1,
    output reg        rate_fail,
    output reg        thick_done
);
    // deviation sits far outside capture until the bench lets the rate settle
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rate_dev0  <= 8'h50;
            rate_dev1  <= 8'h60;
            pid_power0 <= 8'h00;
            pid_power1 <= 8'h00;
            rate_fail  <= 1'b0;
            thick_done <= 1'b0;
        end else begin
            rate_dev0  <= settle ? 8'h03 : 8'h50;
            rate_dev1  <= settle ? 8'h05 : 8'h60;
            pid_power0 <= 8'h5A;
            pid_power1 <= 8'h4B;
            rate_fail  <= fail_req;
            // film only grows while the shutter is open
            thick_done <= done_req && shutter_open;
        end
    end
endmodule // source_model

// file: dv/tb_deposition_phase_sequencer.sv
/* Self-checking bench for the deposition phase sequencer.
   Assumes the register map of phase_seq_defs.vh and a short base tick. */
`timescale 1ns/1ns
`include "phase_seq_defs.vh"
module tb_deposition_phase_sequencer;
    typedef struct packed { logic wr; logic [5:0] a; logic [31:0] d; } row_t;
    logic        mclk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic        start_in = 1'b0, stop_in = 1'b0, settle = 1'b0, fail_req = 1'b0, done_req = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, st;
    logic [7:0]  knob_power = 8'h00, rate_dev0, rate_dev1, pid_power0, pid_power1, power0, power1;
    logic        avs_waitrequest, rate_fail, thick_done, shutter_open, thk_hold;
    logic [3:0]  seen[$];
    int          err_total = 0, n_checks = 0, n6 = 0;
    // reads carry the expected value in d; one manual layer on both outputs
    row_t rows[] = '{'{1'b0, `A_STATUS, 32'h0}, '{1'b0, `A_POWER, 32'h0}, '{1'b1, `A_CTRL, 32'h3},
        '{1'b0, `A_CTRL, 32'h3}, '{1'b1, `A_CTRL, 32'hD}, '{1'b0, `A_CTRL, 32'hD}, '{1'b1, `A_CTRL, 32'h11},
        '{1'b0, `A_CTRL, 32'h11}, '{1'b1, `A_PSEL, 32'h18}, '{1'b1, `A_PSEL, 32'h19}, '{1'b0, `A_PSEL, 32'h18},
        '{1'b1, 6'h34, 32'hFFFF}, '{1'b0, 6'h34, 32'h0}, '{1'b1, `A_FIRST_POWER_RAMP, 32'h240}, '{1'b1, `A_RAMP2, 32'h260},
        '{1'b1, `A_SOAK, 32'h20003}, '{1'b1, `A_CAPT, 32'hA0014}, '{1'b1, `A_FEED, 32'h21030},
        '{1'b1, `A_TIMES, 32'h20002}, '{1'b1, `A_SAMPLE, 32'h20002}, '{1'b1, `A_LAYER, 32'h30400},
        '{1'b1, `A_PROC, 32'h8000}, '{1'b1, `A_PSEL, 32'h0}, '{1'b1, `A_CTRL, 32'h1}};

    deposition_phase_sequencer #(.TICK_CYCLES(4)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .start_in(start_in), .stop_in(stop_in), .knob_power(knob_power), .rate_dev0(rate_dev0),
        .rate_dev1(rate_dev1), .pid_power0(pid_power0), .pid_power1(pid_power1), .rate_fail(rate_fail),
        .thick_done(thick_done), .power0(power0), .power1(power1), .shutter_open(shutter_open),
        .thk_hold(thk_hold));
    source_model far_u (
        .mclk(mclk), .rst_n(rst_n), .shutter_open(shutter_open), .settle(settle), .fail_req(fail_req),
        .done_req(done_req), .rate_dev0(rate_dev0), .rate_dev1(rate_dev1), .pid_power0(pid_power0),
        .pid_power1(pid_power1), .rate_fail(rate_fail), .thick_done(thick_done));

    always #5 mclk = ~mclk;
    // ----------------
    // tasks
    // ----------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // entered just after an edge; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd_st;
        bus(1'b0, `A_STATUS, 32'h0, st);
    endtask
    task automatic kick(input logic stp);
        if (stp) stop_in <= 1'b1;
        else start_in <= 1'b1;
        @(posedge mclk);
        stop_in <= 1'b0;
        start_in <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wait_ph(input logic [3:0] p);
        rd_st();
        for (int n = 0; n < 300 && st[3:0] !== p; n++) rd_st();
    endtask
    // ----------------
    // tests
    // ----------------
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        $display("mismatch watchdog expected finish seen hang");
        final_report();
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        foreach (rows[i]) begin
            bus(rows[i].wr, rows[i].a, rows[i].d, st);
            if (!rows[i].wr) chk("register read", rows[i].d, st);
        end
        $display("test registers done");
        st = 32'h0;
        kick(1'b0);
        for (int i = 0; i < 400 && st[3:0] !== 4'hB; i++) begin
            rd_st();
            if (st[3:0] == 4'h1) chk("first_power_ramp ceiling", 32'h1, {31'h0, power0 <= 8'h40});
            if (st[3:0] == 4'h6 && !settle) chk("shutter in delay", 32'h0, {31'h0, shutter_open});
            if (st[3:0] == 4'h7 && !done_req) chk("shutter in deposit", 32'h1, {31'h0, shutter_open});
            if (st[3:0] != 4'h0 && st[3:0] != 4'hA && (seen.size() == 0 || seen[$] != st[3:0]))
                seen.push_back(st[3:0]);
            else if (st[3:0] == 4'h2) chk("soak1 power", 32'h40, {24'h0, power0});
            else if (st[3:0] == 4'h4) chk("soak2 power", 32'h60, {24'h0, power0});
            else if (st[3:0] == 4'h6 && ++n6 == 4) settle <= 1'b1;
            else if (st[3:0] == 4'h7) done_req <= 1'b1;
        end
        done_req <= 1'b0;
        chk("phase count", 32'hA, seen.size());
        foreach (seen[i]) chk("phase order", i < 9 ? i + 1 : 32'hB, seen[i]);
        $display("test layer sequence done");
        kick(1'b1);
        bus(1'b1, `A_CTRL, 32'h0, st);
        knob_power <= 8'h37;
        kick(1'b0);
        repeat (3) @(posedge mclk);
        chk("manual power", 32'h37, {24'h0, power0});
        knob_power <= 8'h9C;
        repeat (3) @(posedge mclk);
        chk("knob follow", 32'h9C, {24'h0, power0});
        bus(1'b1, `A_CTRL, 32'h1, st);
        repeat (3) @(posedge mclk);
        chk("closed loop power", 32'h5A, {24'h0, power0});
        kick(1'b1);
        repeat (2) @(posedge mclk);
        chk("stop power", 32'h0, {16'h0, power1, power0});
        $display("test manual and stop done");
        settle <= 1'b0;
        bus(1'b1, `A_CAPT, 32'hA0002, st);
        kick(1'b0);
        wait_ph(4'h0);
        chk("capture error", 32'h1, {31'h0, st[4]});
        chk("error power", 32'h0, {24'h0, power0});
        bus(1'b1, `A_CAPT, 32'hA0014, st);
        bus(1'b1, `A_CTRL, 32'h5, st);
        settle <= 1'b1;
        kick(1'b0);
        rd_st();
        chk("error cleared", 32'h0, {31'h0, st[4]});
        wait_ph(4'h7);
        fail_req <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("hold mode", 32'h1, {31'h0, thk_hold});
        rd_st();
        chk("rate error", 32'h1, {31'h0, st[5]});
        fail_req <= 1'b0;
        kick(1'b1);
        $display("test errors done");
        final_report();
    end
endmodule // tb_deposition_phase_sequencer
